// ===== src/nfh_host.sv
`timescale 1ns/1ps
`default_nettype none
module nfh_host
  import nfh_pkg::*;
(
  input wire logic CLK_SYS,            // 40 MHz clock
  input wire logic RST,                // Async reset, high
  input wire logic OP_VALID,           // Request strobe
  output logic OP_READY,               // Engine idle
  input wire logic [1:0] OP_KIND,      // nfh_op_t operation
  input wire logic [7:0] OP_DATA,      // Command, address or data byte
  input wire logic OP_LAST_ADDR,       // Fourth address cycle
  output logic RD_VALID,               // Read byte pulse
  output logic [7:0] RD_DATA,          // Read byte
  output logic BUSY,                   // Device busy, synchronised
  input wire logic SEL_RELEASE,        // Raise select when idle
  input wire logic PROTECT,            // Assert write protect
  output logic REFUSED,                // Request refused pulse
  output logic CHIP_SELECT_N,          // Chip select pin
  output logic COMMAND_LATCH_STROBE,   // Command latch pin
  output logic ADDRESS_LATCH_STROBE,   // Address latch pin
  output logic INPUT_STROBE_N,         // Write strobe pin
  output logic OUTPUT_STROBE_N,        // Read strobe pin
  output logic WRITE_PROTECT_N,        // Write protect pin
  input wire logic READY_BUSY_N,       // Open drain, pulled up
  input wire logic [7:0] BUS_I,        // Shared byte bus in
  output logic [7:0] BUS_O,            // Shared byte bus out
  output logic BUS_OE                  // High while host drives bus
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WLOW, S_WHIGH, S_RLOW, S_RHIGH} nfh_st_t;
  nfh_st_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] busq;
  logic rbq;
  logic busy_s;
  nfh_op_t kind_r;
  logic [7:0] last_cmd_r;
  logic [3:0] wb_r;
  logic [3:0] ww_r;
  logic [3:0] ceh_r;
  logic busy_cmd_ok;
  logic take;
  logic refuse;
  logic last_addr_r;

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  // Busy level is synchronised, so reset leaves it idle as the pull-up does
  nfh_sync #(.W(1)) u_sync_rb (.clk(CLK_SYS), .rst(RST), .d(!READY_BUSY_N),
    .q(rbq));
  nfh_sync #(.W(8)) u_sync_bus (.clk(CLK_SYS), .rst(RST), .d(BUS_I), .q(busq));

  // Busy is also assumed for tWB after array starts, reset and a read's last address, since the pin lags
  assign busy_s = rbq | (wb_r != CY_ZERO);
  assign BUSY = busy_s;

  // ----------------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------------
  // While busy only reset and status commands go out, and status is read back
  assign busy_cmd_ok = ((nfh_op_t'(OP_KIND) == OP_CMD) &&
                        ((OP_DATA == CMD_RESET) || (OP_DATA == CMD_STATUS) ||
                         (OP_DATA == CMD_STATUS2))) ||
                       ((nfh_op_t'(OP_KIND) == OP_RDATA) &&
                        ((last_cmd_r == CMD_STATUS) || (last_cmd_r == CMD_STATUS2)));
  assign OP_READY = (st_r == S_IDLE) && (ceh_r == CY_ZERO);
  // Program and erase refused when protected or protect not yet settled
  assign refuse = (busy_s && !busy_cmd_ok) ||
                  ((nfh_op_t'(OP_KIND) == OP_CMD) && (PROTECT || ww_r != CY_ZERO) &&
                   ((OP_DATA == CMD_SERIAL_IN) || (OP_DATA == CMD_ERASE_GO) ||
                    (OP_DATA == CMD_PROG) || (OP_DATA == CMD_PROG_DUMMY) ||
                    (OP_DATA == CMD_PROG_MULTI) || (OP_DATA == CMD_ERASE_SETUP)));
  assign take = OP_VALID && OP_READY && !refuse;

  // Refusal is reported for one cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      REFUSED <= 1'b0;
    end else begin
      REFUSED <= OP_VALID && OP_READY && refuse;
    end
  end

  // ----------------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_r <= S_IDLE;
      cnt_r <= CY_ZERO;
      kind_r <= OP_CMD;
      last_addr_r <= 1'b0;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (take) begin
            kind_r <= nfh_op_t'(OP_KIND);
            // Kept here so a request changing mid-cycle cannot fake a last address
            last_addr_r <= OP_LAST_ADDR;
            st_r <= S_SETUP;
            cnt_r <= CY_ONE;
          end
        end
        S_SETUP: begin
          // Latch qualifiers settle one cycle before the strobe falls
          if (kind_r == OP_RDATA) begin
            st_r <= S_RLOW;
            cnt_r <= CY_RP;
          end else begin
            st_r <= S_WLOW;
            cnt_r <= CY_WP;
          end
        end
        S_WLOW: begin
          if (cnt_r == CY_ONE) begin
            st_r <= S_WHIGH;
            cnt_r <= (CY_WHR > CY_WH) ? CY_WHR : CY_WH;
          end else begin
            cnt_r <= cnt_r - CY_ONE;
          end
        end
        S_RLOW: begin
          if (cnt_r == CY_ONE) begin
            st_r <= S_RHIGH;
            cnt_r <= CY_REH;
          end else begin
            cnt_r <= cnt_r - CY_ONE;
          end
        end
        S_WHIGH, S_RHIGH: begin
          if (cnt_r == CY_ONE) begin
            st_r <= S_IDLE;
            cnt_r <= CY_ZERO;
          end else begin
            cnt_r <= cnt_r - CY_ONE;
          end
        end
        default: begin
          st_r <= S_IDLE;
          cnt_r <= CY_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  // Latch pins held through the strobe so the rising edge samples them
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      COMMAND_LATCH_STROBE <= 1'b0;
      ADDRESS_LATCH_STROBE <= 1'b0;
      INPUT_STROBE_N <= 1'b1;
      OUTPUT_STROBE_N <= 1'b1;
      BUS_O <= 8'h00;
      BUS_OE <= 1'b0;
    end else begin
      if (take) begin
        COMMAND_LATCH_STROBE <= nfh_op_t'(OP_KIND) == OP_CMD;
        ADDRESS_LATCH_STROBE <= nfh_op_t'(OP_KIND) == OP_ADDR;
        // Bit 7 to line eight; last address cycle keeps lines 3-8 low
        BUS_O <= (OP_LAST_ADDR && nfh_op_t'(OP_KIND) == OP_ADDR) ?
                 {6'h00, OP_DATA[1:0] & LAST_ADDR_MASK} : OP_DATA;
        BUS_OE <= nfh_op_t'(OP_KIND) != OP_RDATA;
      end else if (st_r == S_IDLE) begin
        COMMAND_LATCH_STROBE <= 1'b0;
        ADDRESS_LATCH_STROBE <= 1'b0;
        BUS_OE <= 1'b0;
      end
      INPUT_STROBE_N <= !((st_r == S_SETUP && kind_r != OP_RDATA) ||
                          (st_r == S_WLOW && cnt_r != CY_ONE));
      // Falling read strobe advances the device column counter
      OUTPUT_STROBE_N <= !((st_r == S_SETUP && kind_r == OP_RDATA) ||
                           (st_r == S_RLOW && cnt_r != CY_ONE));
    end
  end

  // ----------------------------------------------------------------------
  // Read data capture
  // ----------------------------------------------------------------------
  // Sampled after the strobe rises; the synchroniser adds two cycles
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RD_VALID <= 1'b0;
      RD_DATA <= 8'h00;
    end else begin
      RD_VALID <= (st_r == S_RHIGH) && (cnt_r == CY_ONE);
      if ((st_r == S_RHIGH) && (cnt_r == CY_ONE)) begin
        RD_DATA <= busq;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Busy window, protect settle and select control
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      last_cmd_r <= CMD_RESET;
      wb_r <= CY_ZERO;
    end else begin
      if (take && nfh_op_t'(OP_KIND) == OP_CMD) begin
        last_cmd_r <= OP_DATA;
      end
      // Only array starts and reset open the tWB window; a read starts at its last address
      if (st_r == S_WHIGH && cnt_r == CY_ONE && kind_r == OP_CMD &&
          (last_cmd_r == CMD_PROG || last_cmd_r == CMD_PROG_DUMMY ||
           last_cmd_r == CMD_PROG_MULTI || last_cmd_r == CMD_ERASE_GO ||
           last_cmd_r == CMD_RESET)) begin
        wb_r <= CY_WB;
      end else if (st_r == S_WHIGH && cnt_r == CY_ONE && kind_r == OP_ADDR &&
                   last_addr_r &&
                   (last_cmd_r == CMD_READ_MAIN || last_cmd_r == CMD_READ_HIGH ||
                    last_cmd_r == CMD_READ_SPARE)) begin
        wb_r <= CY_WB;
      end else if (wb_r != CY_ZERO) begin
        wb_r <= wb_r - CY_ONE;
      end
    end
  end

  // Protect pin and settle time before writes
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WRITE_PROTECT_N <= 1'b0;
      ww_r <= CY_WW;
    end else begin
      WRITE_PROTECT_N <= !PROTECT;
      if (PROTECT) begin
        ww_r <= CY_WW;
      end else if (ww_r != CY_ZERO) begin
        ww_r <= ww_r - CY_ONE;
      end
    end
  end

  // Select stays low while busy so array data reaches the register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CHIP_SELECT_N <= 1'b1;
      ceh_r <= CY_ZERO;
    end else begin
      if (st_r != S_IDLE || take || busy_s) begin
        CHIP_SELECT_N <= 1'b0;
        ceh_r <= CY_ZERO;
      end else if (SEL_RELEASE) begin
        if (!CHIP_SELECT_N) begin
          ceh_r <= CY_CEH;
        end else if (ceh_r != CY_ZERO) begin
          ceh_r <= ceh_r - CY_ONE;
        end
        CHIP_SELECT_N <= 1'b1;
      end else begin
        CHIP_SELECT_N <= 1'b0;
        ceh_r <= CY_ZERO;
      end
    end
  end
endmodule
`default_nettype wire

// ===== pkg/nfh_pkg.sv
// Overview of operation
// - Command byte latched on write strobe rising edge while command latch high.
// - Address byte latched on write strobe rising edge while address latch high.
// - Both latches low during write strobe means the byte is input data.
// - Host keeps select low through the busy period after a read command.
// - Address is four cycles: A0-A7, A9-A16, A17-A24, A25-A26.
// - Host drives bus lines three to eight low in fourth address cycle.
// - Cycle type decoded from latches, select and strobes.
// - Command bit 7 on bus line eight, bit 0 on line one.
package nfh_pkg;
  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_READ_MAIN = 8'h00;
  localparam logic [7:0] CMD_READ_HIGH = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG = 8'h10;
  localparam logic [7:0] CMD_PROG_DUMMY = 8'h11;
  localparam logic [7:0] CMD_PROG_MULTI = 8'h15;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS2 = 8'h71;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_ID2 = 8'h91;
  // ----------------------------------------------------------------------
  // Geometry and status bits
  // ----------------------------------------------------------------------
  localparam int PAGE_BYTES = 528;
  localparam int MAIN_BYTES = 512;
  localparam int SPARE_BYTES = 16;
  localparam int PAGES_PER_BLOCK = 32;
  localparam int BLOCKS = 8192;
  localparam int ADDR_CYCLES = 4;
  localparam int ADDR_CYCLES_ERASE = 3;
  localparam logic [1:0] LAST_ADDR_MASK = 2'h3;
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_READY_BIT = 6;
  localparam int ST_WP_BIT = 7;
  // ----------------------------------------------------------------------
  // Timing, 40 MHz system clock
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int T_WP_NS = 25;   // Write strobe low width
  localparam int T_WH_NS = 15;   // Write strobe high hold
  localparam int T_RP_NS = 35;   // Read pulse width
  localparam int T_REH_NS = 15;  // Read strobe high hold
  localparam int T_WB_NS = 200;  // Write high to busy, longest
  localparam int T_WHR_NS = 30;  // Write high to read low
  localparam int T_CEH_NS = 100; // Select high to end sequential read
  localparam int T_WW_NS = 100;  // Protect high to write low
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [3:0] CY_WP = 4'(cyc_up(T_WP_NS));
  localparam logic [3:0] CY_WH = 4'(cyc_up(T_WH_NS));
  localparam logic [3:0] CY_RP = 4'(cyc_up(T_RP_NS));
  localparam logic [3:0] CY_REH = 4'(cyc_up(T_REH_NS));
  localparam logic [3:0] CY_WB = 4'(cyc_up(T_WB_NS));
  localparam logic [3:0] CY_WHR = 4'(cyc_up(T_WHR_NS));
  localparam logic [3:0] CY_CEH = 4'(cyc_up(T_CEH_NS));
  localparam logic [3:0] CY_WW = 4'(cyc_up(T_WW_NS));
  localparam logic [3:0] CY_ZERO = 4'h0;
  localparam logic [3:0] CY_ONE = 4'h1;
  // Host operations
  typedef enum logic [1:0] {OP_CMD, OP_ADDR, OP_WDATA, OP_RDATA} nfh_op_t;
endpackage

// ===== src/nfh_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------------
// Two flop synchroniser for pin inputs
// ------------------------------------------------------------------------
module nfh_sync #(
  parameter int W = 1
) (
  input wire logic clk,          // System clock
  input wire logic rst,          // Async reset
  input wire logic [W-1:0] d,    // Asynchronous level
  output logic [W-1:0] q         // Synchronised level
);
  logic [W-1:0] meta_r;
  // Only the second flop reads the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== verification/nfh_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Pin protocol checker
// ----------------------------------------
module nfh_host_monitor
  import nfh_pkg::*;
(
  input wire logic CLK_SYS, // Clock
  input wire logic RST, // Reset
  input wire logic OP_VALID, // Request
  input wire logic OP_READY, // Idle
  input wire logic [1:0] OP_KIND, // Kind
  input wire logic [7:0] OP_DATA, // Byte
  input wire logic OP_LAST_ADDR, // Fourth address
  input wire logic RD_VALID, // Read pulse
  input wire logic BUSY, // Busy
  input wire logic PROTECT, // Protect order
  input wire logic REFUSED, // Refusal
  input wire logic COMMAND_LATCH_STROBE, // Cmd latch
  input wire logic ADDRESS_LATCH_STROBE, // Addr latch
  input wire logic INPUT_STROBE_N, // Write strobe
  input wire logic OUTPUT_STROBE_N, // Read strobe
  input wire logic WRITE_PROTECT_N, // Protect pin
  input wire logic [7:0] BUS_O, // Bus out
  input wire logic BUS_OE // Bus enable
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  a_cmd_qual: assert property (
    $rose(INPUT_STROBE_N) && COMMAND_LATCH_STROBE |-> !ADDRESS_LATCH_STROBE && BUS_OE)
    else $error("bad command cycle");
  a_addr_qual: assert property (
    $rose(INPUT_STROBE_N) && ADDRESS_LATCH_STROBE |-> !COMMAND_LATCH_STROBE && BUS_OE)
    else $error("bad address cycle");
  a_last_addr_low: assert property (
    OP_VALID && OP_READY && !BUSY && OP_KIND == OP_ADDR && OP_LAST_ADDR
    |=> ADDRESS_LATCH_STROBE && BUS_O[7:2] == 6'h00)
    else $error("fourth address high lines set");
  a_cmd_bit_order: assert property (
    OP_VALID && OP_READY && OP_KIND == OP_CMD && OP_DATA == CMD_STATUS
    |=> COMMAND_LATCH_STROBE && BUS_O == CMD_STATUS) else $error("command byte wrong");
  a_read_bus_free: assert property (
    !OUTPUT_STROBE_N |-> !BUS_OE && INPUT_STROBE_N && !COMMAND_LATCH_STROBE)
    else $error("host drives bus in read");
  a_read_answer: assert property (
    $fell(OUTPUT_STROBE_N) |-> ##3 RD_VALID) else $error("read byte late");
  a_protect_refuse: assert property (
    PROTECT && OP_VALID && OP_READY && OP_KIND == OP_CMD && OP_DATA == CMD_PROG
    |=> REFUSED && INPUT_STROBE_N && !WRITE_PROTECT_N) else $error("program not refused");
  a_busy_refuse: assert property (
    BUSY && OP_VALID && OP_READY && OP_KIND == OP_CMD && OP_DATA == CMD_READ_MAIN
    |=> REFUSED && INPUT_STROBE_N) else $error("busy command not refused");
endmodule
bind nfh_host nfh_host_monitor mon (.CLK_SYS(CLK_SYS), .RST(RST), .OP_VALID(OP_VALID),
  .OP_READY(OP_READY), .OP_KIND(OP_KIND), .OP_DATA(OP_DATA), .OP_LAST_ADDR(OP_LAST_ADDR),
  .RD_VALID(RD_VALID), .BUSY(BUSY), .PROTECT(PROTECT), .REFUSED(REFUSED),
  .COMMAND_LATCH_STROBE(COMMAND_LATCH_STROBE), .ADDRESS_LATCH_STROBE(ADDRESS_LATCH_STROBE),
  .INPUT_STROBE_N(INPUT_STROBE_N), .OUTPUT_STROBE_N(OUTPUT_STROBE_N),
  .WRITE_PROTECT_N(WRITE_PROTECT_N), .BUS_O(BUS_O), .BUS_OE(BUS_OE));
`default_nettype wire

// ===== verification/nfh_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Behavioural flash device
// ----------------------------------------
module nfh_dev_model
  import nfh_pkg::*;
#(
  parameter int BUSY_NS = 2000 // Array busy time, shortened
) (
  input wire logic ce_n, // Select
  input wire logic cle, // Cmd latch
  input wire logic ale, // Addr latch
  input wire logic we_n, // Write strobe
  input wire logic re_n, // Read strobe
  input wire logic wp_n, // Protect
  input wire logic [7:0] bus_in, // Bus
  output logic rb_low, // Open drain pull
  output logic [7:0] dq, // Drive value
  output logic dq_oe // Drive enable
);
  logic [7:0] col_r = 8'h00;
  logic half_r = 1'b0;
  logic stat_r = 1'b0;
  int acnt = 0;
  initial rb_low = 1'b0;
  initial dq = 8'h00;
  initial dq_oe = 1'b0;
  // Busy after write-to-busy delay; select is not looked at
  task automatic go_busy();
    fork
      begin
        #100;
        rb_low = 1'b1;
        #(BUSY_NS);
        rb_low = 1'b0;
      end
    join_none
  endtask
  // Latch on rising write strobe; busy drops most commands
  always @(posedge we_n) begin
    if (!ce_n && cle && (!rb_low || bus_in inside {CMD_RESET, CMD_STATUS, CMD_STATUS2})) begin
      stat_r = (bus_in == CMD_STATUS);
      acnt = 0;
      if (bus_in inside {CMD_READ_MAIN, CMD_READ_HIGH}) half_r = bus_in[0];
      if (bus_in == CMD_PROG && wp_n) go_busy();
    end else if (!ce_n && ale) begin
      if (acnt == 0) col_r = bus_in;
      if (acnt == 3) go_busy();
      acnt++;
    end
  end
  // Next byte on falling read strobe, column steps by one
  always @(negedge re_n) begin
    dq_oe = !ce_n;
    dq = stat_r ? {wp_n, !rb_low, 5'h00, 1'b0} : col_r ^ {8{half_r}};
    if (!stat_r) col_r = col_r + 8'h01;
  end
  // Float on strobe high or deselect
  always @(posedge re_n or posedge ce_n) dq_oe = 1'b0;
endmodule
`default_nettype wire

// ===== verification/nfh_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nfh_host_tb
  import nfh_pkg::*;
;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic OP_VALID = 1'b0;
  logic [1:0] OP_KIND = 2'h0;
  logic [7:0] OP_DATA = 8'h00;
  logic OP_LAST_ADDR = 1'b0;
  logic SEL_RELEASE = 1'b0;
  logic PROTECT = 1'b0;
  logic OP_READY, RD_VALID, BUSY, REFUSED, CHIP_SELECT_N, COMMAND_LATCH_STROBE;
  logic ADDRESS_LATCH_STROBE, INPUT_STROBE_N, OUTPUT_STROBE_N, WRITE_PROTECT_N;
  logic BUS_OE, READY_BUSY_N, rb_low, dev_oe, refd;
  logic [7:0] RD_DATA, BUS_O, BUS_I, dev_dq;
  int fails = 0;
  int samples_checked = 0;
  always #12.5 CLK_SYS = ~CLK_SYS;
  // Pull-up on ready line; released data bus shows inverse of last byte
  assign READY_BUSY_N = rb_low ? 1'b0 : 1'b1;
  assign BUS_I = BUS_OE ? BUS_O : (dev_oe ? dev_dq : ~dev_dq);
  nfh_host dut (.CLK_SYS(CLK_SYS), .RST(RST), .OP_VALID(OP_VALID), .OP_READY(OP_READY),
    .OP_KIND(OP_KIND), .OP_DATA(OP_DATA), .OP_LAST_ADDR(OP_LAST_ADDR), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA), .BUSY(BUSY), .SEL_RELEASE(SEL_RELEASE), .PROTECT(PROTECT),
    .REFUSED(REFUSED), .CHIP_SELECT_N(CHIP_SELECT_N),
    .COMMAND_LATCH_STROBE(COMMAND_LATCH_STROBE), .ADDRESS_LATCH_STROBE(ADDRESS_LATCH_STROBE),
    .INPUT_STROBE_N(INPUT_STROBE_N), .OUTPUT_STROBE_N(OUTPUT_STROBE_N),
    .WRITE_PROTECT_N(WRITE_PROTECT_N), .READY_BUSY_N(READY_BUSY_N), .BUS_I(BUS_I),
    .BUS_O(BUS_O), .BUS_OE(BUS_OE));
  nfh_dev_model dev (.ce_n(CHIP_SELECT_N), .cle(COMMAND_LATCH_STROBE),
    .ale(ADDRESS_LATCH_STROBE), .we_n(INPUT_STROBE_N), .re_n(OUTPUT_STROBE_N),
    .wp_n(WRITE_PROTECT_N), .bus_in(BUS_O), .rb_low(rb_low), .dq(dev_dq), .dq_oe(dev_oe));
  task automatic test_done();
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  // Request held until the engine is ready; refusal pulse read just after
  task automatic op(input logic [1:0] k, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    OP_VALID <= 1'b1;
    OP_KIND <= k;
    OP_DATA <= d;
    OP_LAST_ADDR <= l;
    do @(posedge CLK_SYS); while (OP_READY !== 1'b1 && ++n < 100);
    OP_VALID <= 1'b0;
    chk({7'h00, OP_READY}, 8'h01);
    #1 refd = REFUSED;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [7:0] exp);
    op(OP_RDATA, 8'h00, 1'b0);
    repeat (8) if (RD_VALID !== 1'b1) @(posedge CLK_SYS);
    chk({7'h00, RD_VALID}, 8'h01);
    chk(RD_DATA, exp);
  endtask
  task automatic wait_ready();
    repeat (300) if (BUSY !== 1'b0) @(posedge CLK_SYS);
    chk({7'h00, BUSY}, 8'h00);
  endtask
  task automatic addr4();
    for (int i = 0; i < 4; i++) op(OP_ADDR, (i == 3) ? 8'hFF : 8'h05, i == 3);
  endtask
  // Array read, then two bytes in the chosen half
  task automatic t_page(input logic [7:0] c);
    op(OP_CMD, c, 1'b0);
    addr4();
    // Let the last strobe finish, so the busy window has opened
    repeat (5) @(posedge CLK_SYS);
    chk({7'h00, BUSY}, 8'h01);
    wait_ready();
    rd(8'h05 ^ {8{c[0]}});
    rd(8'h06 ^ {8{c[0]}});
  endtask
  // Of the commands tried, only status passes while busy; reset also passes but is not tried
  task automatic t_busy();
    logic [7:0] cl [11] = '{8'h80, 8'h00, 8'h01, 8'h50, 8'h10, 8'h11, 8'h15,
      8'h60, 8'hD0, 8'h90, 8'h91};
    op(OP_CMD, CMD_READ_MAIN, 1'b0);
    addr4();
    foreach (cl[i]) begin
      op(OP_CMD, cl[i], 1'b0);
      chk({7'h00, refd}, 8'h01);
    end
    op(OP_CMD, CMD_STATUS, 1'b0);
    rd(8'h80);
    wait_ready();
  endtask
  // Protected: program and erase refused; unprotected program runs
  task automatic t_protect();
    logic [7:0] pc [6] = '{8'h80, 8'h60, 8'hD0, 8'h10, 8'h11, 8'h15};
    PROTECT <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    foreach (pc[i]) begin
      op(OP_CMD, pc[i], 1'b0);
      chk({7'h00, refd}, 8'h01);
    end
    op(OP_CMD, CMD_STATUS, 1'b0);
    rd(8'h40);
    PROTECT <= 1'b0;
    repeat (8) @(posedge CLK_SYS);
    op(OP_CMD, CMD_SERIAL_IN, 1'b0);
    op(OP_WDATA, 8'hA5, 1'b0);
    op(OP_CMD, CMD_PROG, 1'b0);
    repeat (5) @(posedge CLK_SYS);
    chk({6'h00, refd, BUSY}, 8'h01);
    wait_ready();
    op(OP_CMD, CMD_STATUS, 1'b0);
    rd(8'hC0);
  endtask
  initial begin
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    op(OP_CMD, CMD_STATUS, 1'b0);
    rd(8'hC0);
    t_page(CMD_READ_MAIN);
    t_page(CMD_READ_HIGH);
    t_busy();
    t_protect();
    SEL_RELEASE <= 1'b1;
    repeat (10) @(posedge CLK_SYS);
    chk({7'h00, CHIP_SELECT_N}, 8'h01);
    test_done();
  end
  // Hang guard, well beyond the expected run
  initial begin
    repeat (6000) @(posedge CLK_SYS);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
